// ==== verilog/mpp_defines.vh ====
// constants of the motion profile parameter set
// assumes a 16-bit parameter address with byte-free indices
// Contract
// - scaling numerator 1..2147483647, active on write
// - numerator, max velocity writable only stage off
// - reported user limits shrink with scaling factor
// - position velocity 1..3000, capped, immediate
// - absolute target within scaling and soft limits
// - relative-to-actual adds to motor position
// - relative-to-target adds to current target
// - limit overrun only at standstill, zero first
// - relative bounds from scaling and soft limits
// - velocity mode target -3000..3000, capped, immediate
// - jerk code 0 or powers 1..128, next start
// - jerk writable only while end flag set
// - ramp shape 0 or -1, next stage enable
// - acceleration 1..3000000, default 600, next start
// - deceleration 200..3000000, default 750, next start
// - combined word: high acc, low dec, x10
// - combined write checked against separate ranges
// - combined read halves saturate to 65535
// - max velocity 60..13200 clamps reference velocity
// - start/stop velocity active on next stage enable
`ifndef MPP_DEFINES_VH
`define MPP_DEFINES_VH

`define MPP_A_NUM 16'h0610
`define MPP_A_VMAX 16'h0612
`define MPP_A_ACC 16'h0614
`define MPP_A_DEC 16'h0616
`define MPP_A_JERK 16'h061a
`define MPP_A_SS 16'h0622
`define MPP_A_TYPE 16'h0626
`define MPP_A_PPV 16'h0700
`define MPP_A_ABS 16'h0702
`define MPP_A_RELA 16'h0704
`define MPP_A_RELT 16'h0706
`define MPP_A_PV 16'h0708
`define MPP_A_COMB 16'h070a

`define MPP_RST_NUM 32'h00000001
`define MPP_RST_VMAX 16'h3390
`define MPP_RST_ACC 32'h00000258
`define MPP_RST_DEC 32'h000002ee
`define MPP_RST_JERK 16'h0000
`define MPP_RST_SS 16'h0000
`define MPP_RST_TYPE 16'h0000
`define MPP_RST_PPV 16'h003c

`define MPP_NUM_MAX 32'h7fffffff
`define MPP_VMAX_MIN 32'h0000003c
`define MPP_VMAX_MAX 32'h00003390
`define MPP_ACC_MIN 32'h00000001
`define MPP_DEC_MIN 32'h000000c8
`define MPP_RAMP_MAX 32'h002dc6c0
`define MPP_JERK_MAX 32'h00000080
`define MPP_PPV_MIN 32'h00000001
`define MPP_VEL_MAX 32'h00000bb8
`define MPP_PV_MIN 32'hfffff448
`define MPP_TYPE_LIN 16'h0000
`define MPP_TYPE_OPT 16'hffff
`define MPP_COMB_SCALE 32'h0000000a
`define MPP_U16_MAX 32'h0000ffff
`define MPP_LIM_FULL 32'h7fffffff
`define MPP_RST_PV 32'h00000000
`define MPP_RST_POS 32'h00000000
`define MPP_RST_REF 16'h0000
`define MPP_ACC_HI 5'h1f
`define MPP_ACC_LO 5'h10
`define MPP_DEC_HI 5'h0f
`define MPP_DEC_LO 5'h00

`endif

// ==== verilog/mpp_params.v ====
// motion profile parameter set with write checks and apply timing
// assumes parameter accesses are single-cycle strobes in the clock domain
`timescale 1ns/10ps
`include "mpp_defines.vh"

module mpp_params (
    input wire clock, // 40 MHz system clock
    input wire rst_b, // async reset, active low
    input wire [15:0] par_addr, // parameter address
    input wire [31:0] par_wdata, // write value
    input wire par_wr, // write strobe
    input wire par_rd, // read strobe
    output reg [31:0] par_rdata, // read value
    output reg par_ack, // access done pulse
    output reg par_err, // access refused pulse
    input wire stage_on, // power stage enabled
    input wire op_end, // operating mode inactive
    input wire motion_start, // motion start pulse
    input wire [31:0] motor_pos, // actual position, usr
    input wire sw_lim_en, // software limit switches on
    input wire [31:0] sw_lim_min, // soft negative limit
    input wire [31:0] sw_lim_max, // soft positive limit
    input wire vel_clamp_mode, // pp, pv, homing or jog
    input wire [15:0] ref_vel_in, // reference velocity
    output reg [31:0] scale_num, // active numerator
    output reg [31:0] usr_lim_min, // reduced lower limit
    output reg [31:0] usr_lim_max, // reduced upper limit
    output reg [31:0] acc_act, // active acceleration
    output reg [31:0] dec_act, // active deceleration
    output reg [15:0] jerk_act, // active jerk time, ms
    output reg [15:0] vmax_act, // active max velocity
    output reg [15:0] shape_act, // active ramp shape
    output reg [15:0] ss_vel_act, // active start/stop vel
    output reg [15:0] pp_vel_out, // capped pp velocity
    output reg [31:0] pv_vel_out, // capped pv velocity
    output reg [15:0] ref_vel_out, // clamped reference
    output reg [31:0] target_pos, // target position
    output reg target_new, // new target pulse
    output reg pos_zero // position set to 0 pulse
);

////////////////////////////////////////////////////////////

function [5:0] clog2_32;
    input [31:0] v;
    integer i;
    begin
        clog2_32 = 6'h00;
        for (i = 0; i < 32; i = i + 1) begin
            if ((33'h000000001 << i) < {1'b0, v}) begin
                clog2_32 = clog2_32 + 6'h01;
            end
        end
    end
endfunction

function in_range;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
        in_range = (v >= lo) && (v <= hi);
    end
endfunction

function in_lim;
    input [32:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
        in_lim = ($signed(v) >= $signed({lo[31], lo})) &&
                 ($signed(v) <= $signed({hi[31], hi}));
    end
endfunction

function [15:0] cap16;
    input [15:0] v;
    input [15:0] cap;
    begin
        cap16 = (v > cap) ? cap : v;
    end
endfunction

// the code is a time in ms: zero or one set bit up to the top code
function jerk_code_ok;
    input [31:0] v;
    begin
        jerk_code_ok = (v <= `MPP_JERK_MAX) &&
                       ((v & (v - 32'h00000001)) == 32'h00000000);
    end
endfunction

// symmetric clamp: the cap bounds both turning directions
function [31:0] clamp_sym;
    input [31:0] v;
    input [31:0] cap;
    begin
        if ($signed(v) > $signed(cap)) begin
            clamp_sym = cap;
        end else if ($signed(v) < -$signed(cap)) begin
            clamp_sym = 32'h00000000 - cap;
        end else begin
            clamp_sym = v;
        end
    end
endfunction

// read side of the combined word loses the x10 scale
function [15:0] div10_sat;
    input [31:0] v;
    reg [31:0] q;
    begin
        q = v / `MPP_COMB_SCALE;
        div10_sat = (q > `MPP_U16_MAX) ? 16'hffff : q[15:0];
    end
endfunction

////////////////////////////////////////////////////////////
// pending values, as software last wrote them

reg [15:0] vmax_r;
reg [31:0] acc_r;
reg [31:0] dec_r;
reg [15:0] jerk_r;
reg [15:0] ss_r;
reg [15:0] shape_r;
reg [15:0] ppv_r;
reg [31:0] pv_r;
reg [31:0] rel_a_r;
reg [31:0] rel_t_r;
reg stage_d_r;

////////////////////////////////////////////////////////////
// write checks

reg hit;
reg wr_ok;
reg over;
reg [31:0] comb_acc;
reg [31:0] comb_dec;
reg [32:0] sum_a;
reg [32:0] sum_t;
reg [32:0] rel_sum;
reg [31:0] eff_min;
reg [31:0] eff_max;
reg [31:0] red_max;
reg [31:0] red_min;
reg [31:0] vcap;
reg [31:0] rd_nxt;
wire wr_take;

// storage follows only an accepted write to a mapped address
assign wr_take = par_wr && hit && wr_ok;

always @* begin
    // power-of-two reduction keeps the scaled position inside 31 bits
    red_max = `MPP_LIM_FULL >> clog2_32(scale_num);
    red_min = ~red_max;
    eff_max = red_max;
    eff_min = red_min;
    if (sw_lim_en && ($signed(sw_lim_max) < $signed(red_max))) begin
        eff_max = sw_lim_max;
    end
    if (sw_lim_en && ($signed(sw_lim_min) > $signed(red_min))) begin
        eff_min = sw_lim_min;
    end
    comb_acc = {16'h0000, par_wdata[`MPP_ACC_HI:`MPP_ACC_LO]} * `MPP_COMB_SCALE;
    comb_dec = {16'h0000, par_wdata[`MPP_DEC_HI:`MPP_DEC_LO]} * `MPP_COMB_SCALE;
    sum_a = {motor_pos[31], motor_pos} + {par_wdata[31], par_wdata};
    sum_t = {target_pos[31], target_pos} + {par_wdata[31], par_wdata};
    rel_sum = (par_addr == `MPP_A_RELA) ? sum_a : sum_t;
    // a sum outside the limits may still pass from standstill
    over = !in_lim(rel_sum, eff_min, eff_max);
end

////////////////////////////////////////////////////////////
// per-address acceptance

always @* begin
    hit = 1'b1;
    wr_ok = 1'b0;
    case (par_addr)
        `MPP_A_NUM: begin
            wr_ok = !stage_on && in_range(par_wdata, `MPP_RST_NUM, `MPP_NUM_MAX);
        end
        `MPP_A_VMAX: begin
            wr_ok = !stage_on && in_range(par_wdata, `MPP_VMAX_MIN, `MPP_VMAX_MAX);
        end
        `MPP_A_ACC: begin
            wr_ok = in_range(par_wdata, `MPP_ACC_MIN, `MPP_RAMP_MAX);
        end
        `MPP_A_DEC: begin
            wr_ok = in_range(par_wdata, `MPP_DEC_MIN, `MPP_RAMP_MAX);
        end
        `MPP_A_JERK: begin
            wr_ok = op_end && jerk_code_ok(par_wdata);
        end
        `MPP_A_SS: begin
            wr_ok = (par_wdata <= `MPP_U16_MAX);
        end
        `MPP_A_TYPE: begin
            wr_ok = (par_wdata[15:0] == `MPP_TYPE_LIN) || (par_wdata[15:0] == `MPP_TYPE_OPT);
        end
        `MPP_A_PPV: begin
            wr_ok = in_range(par_wdata, `MPP_PPV_MIN, `MPP_VEL_MAX);
        end
        `MPP_A_ABS: begin
            wr_ok = in_lim({par_wdata[31], par_wdata}, eff_min, eff_max);
        end
        `MPP_A_RELA, `MPP_A_RELT: begin
            // overrun restarts from 0, so the distance itself must fit
            wr_ok = !over || (op_end && in_lim({par_wdata[31], par_wdata}, eff_min, eff_max));
        end
        `MPP_A_PV: begin
            wr_ok = ($signed(par_wdata) >= $signed(`MPP_PV_MIN)) &&
                    ($signed(par_wdata) <= $signed(`MPP_VEL_MAX));
        end
        `MPP_A_COMB: begin
            wr_ok = in_range(comb_acc, `MPP_ACC_MIN, `MPP_RAMP_MAX) &&
                    in_range(comb_dec, `MPP_DEC_MIN, `MPP_RAMP_MAX);
        end
        default: begin
            hit = 1'b0;
        end
    endcase
end

////////////////////////////////////////////////////////////
// read mux

always @* begin
    case (par_addr)
        `MPP_A_NUM: rd_nxt = scale_num;
        `MPP_A_VMAX: rd_nxt = {16'h0000, vmax_r};
        `MPP_A_ACC: rd_nxt = acc_r;
        `MPP_A_DEC: rd_nxt = dec_r;
        `MPP_A_JERK: rd_nxt = {16'h0000, jerk_r};
        `MPP_A_SS: rd_nxt = {16'h0000, ss_r};
        `MPP_A_TYPE: rd_nxt = {16'h0000, shape_r};
        `MPP_A_PPV: rd_nxt = {16'h0000, ppv_r};
        `MPP_A_ABS: rd_nxt = target_pos;
        `MPP_A_RELA: rd_nxt = rel_a_r;
        `MPP_A_RELT: rd_nxt = rel_t_r;
        `MPP_A_PV: rd_nxt = pv_r;
        `MPP_A_COMB: rd_nxt = {div10_sat(acc_r), div10_sat(dec_r)};
        default: rd_nxt = 32'h00000000;
    endcase
end

////////////////////////////////////////////////////////////
// parameter storage and access answer

always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        par_rdata <= 32'h00000000;
        par_ack <= 1'b0;
        par_err <= 1'b0;
        scale_num <= `MPP_RST_NUM;
        vmax_r <= `MPP_RST_VMAX;
        acc_r <= `MPP_RST_ACC;
        dec_r <= `MPP_RST_DEC;
        jerk_r <= `MPP_RST_JERK;
        ss_r <= `MPP_RST_SS;
        shape_r <= `MPP_RST_TYPE;
        ppv_r <= `MPP_RST_PPV;
        pv_r <= `MPP_RST_PV;
        rel_a_r <= `MPP_RST_POS;
        rel_t_r <= `MPP_RST_POS;
        target_pos <= `MPP_RST_POS;
        target_new <= 1'b0;
        pos_zero <= 1'b0;
    end else begin
        par_ack <= par_wr || par_rd;
        // an unmapped read is refused too, its data is not to be trusted
        par_err <= (par_wr || par_rd) && (!hit || (par_wr && !wr_ok));
        par_rdata <= par_rd ? rd_nxt : par_rdata;
        target_new <= 1'b0;
        pos_zero <= 1'b0;
        if (wr_take) begin
            case (par_addr)
                `MPP_A_NUM: scale_num <= par_wdata;
                `MPP_A_VMAX: vmax_r <= par_wdata[15:0];
                `MPP_A_ACC: acc_r <= par_wdata;
                `MPP_A_DEC: dec_r <= par_wdata;
                `MPP_A_JERK: jerk_r <= par_wdata[15:0];
                `MPP_A_SS: ss_r <= par_wdata[15:0];
                `MPP_A_TYPE: shape_r <= par_wdata[15:0];
                `MPP_A_PPV: ppv_r <= par_wdata[15:0];
                `MPP_A_PV: pv_r <= par_wdata;
                `MPP_A_COMB: begin
                    acc_r <= comb_acc;
                    dec_r <= comb_dec;
                end
                `MPP_A_ABS: begin
                    target_pos <= par_wdata;
                    target_new <= 1'b1;
                end
                `MPP_A_RELA, `MPP_A_RELT: begin
                    if (par_addr == `MPP_A_RELA) begin
                        rel_a_r <= par_wdata;
                    end else begin
                        rel_t_r <= par_wdata;
                    end
                    target_new <= 1'b1;
                    // crossing limits: position restarts at 0, so target is the distance
                    if (over) begin
                        target_pos <= par_wdata;
                        pos_zero <= 1'b1;
                    end else begin
                        target_pos <= rel_sum[31:0];
                    end
                end
                default: begin
                    target_new <= 1'b0;
                end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////
// apply moments: motion start and stage enable

always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        stage_d_r <= 1'b0;
        acc_act <= `MPP_RST_ACC;
        dec_act <= `MPP_RST_DEC;
        jerk_act <= `MPP_RST_JERK;
        vmax_act <= `MPP_RST_VMAX;
        shape_act <= `MPP_RST_TYPE;
        ss_vel_act <= `MPP_RST_SS;
    end else begin
        stage_d_r <= stage_on;
        if (motion_start) begin
            acc_act <= acc_r;
            dec_act <= dec_r;
            jerk_act <= jerk_r;
            // the limit never moves under a running profile
            vmax_act <= vmax_r;
        end
        // rising edge of the stage enable; the delay resets low
        // because the stage is off after power-on, so no false edge
        if (stage_on && !stage_d_r) begin
            shape_act <= shape_r;
            ss_vel_act <= ss_r;
        end
    end
end

////////////////////////////////////////////////////////////
// capped velocities and reduced limits, one cycle behind

always @* begin
    vcap = {16'h0000, vmax_act};
end

always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        pp_vel_out <= `MPP_RST_PPV;
        pv_vel_out <= `MPP_RST_PV;
        ref_vel_out <= `MPP_RST_REF;
        usr_lim_min <= ~`MPP_LIM_FULL;
        usr_lim_max <= `MPP_LIM_FULL;
    end else begin
        pp_vel_out <= cap16(ppv_r, vmax_act);
        pv_vel_out <= clamp_sym(pv_r, vcap);
        ref_vel_out <= vel_clamp_mode ? cap16(ref_vel_in, vmax_act) : ref_vel_in;
        usr_lim_min <= eff_min;
        usr_lim_max <= eff_max;
    end
end

endmodule // mpp_params

// ==== tb/mpp_master.sv ====
// fieldbus master model issuing single parameter accesses
// assumes the one-cycle strobe and ack timing of the parameter port
`timescale 1ns/10ps
module mpp_master (
    input logic clock, // system clock
    input logic par_ack, // access done
    input logic par_err, // access refused
    input logic [31:0] par_rdata, // read value
    output logic [15:0] par_addr, // address
    output logic [31:0] par_wdata, // write value
    output logic par_wr, // write strobe
    output logic par_rd // read strobe
);
    initial begin
        par_wr = 1'b0;
        par_rd = 1'b0;
        par_addr = 16'h0;
        par_wdata = 32'h0;
    end
    // released lines are scrambled so nothing leans on a stale value
    task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d,
                          output logic e, output logic [31:0] r);
        int n;
        @(posedge clock);
        par_wr <= w;
        par_rd <= !w;
        par_addr <= a;
        par_wdata <= d;
        @(posedge clock);
        par_wr <= 1'b0;
        par_rd <= 1'b0;
        par_addr <= ~a;
        par_wdata <= ~d;
        #1;
        for (n = 0; n < 4 && par_ack !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        e = par_err;
        r = par_rdata;
    endtask
endmodule // mpp_master

// ==== tb/mpp_params_monitor.sv ====
// assertions on the parameter set's ports
// assumes one clock domain and the shared address map
`timescale 1ns/10ps
`include "mpp_defines.vh"
module mpp_params_chk (
    input logic clock, // system clock
    input logic rst_b, // reset, active low
    input logic par_wr, // write strobe
    input logic par_rd, // read strobe
    input logic par_ack, // access done
    input logic par_err, // access refused
    input logic stage_on, // stage enabled
    input logic op_end, // mode inactive
    input logic motion_start, // motion start
    input logic vel_clamp_mode, // clamping modes
    input logic target_new, // new target
    input logic pos_zero, // position zeroed
    input logic [15:0] par_addr, // address
    input logic [15:0] jerk_act, // active jerk
    input logic [15:0] shape_act, // active shape
    input logic [15:0] ss_vel_act, // active start/stop
    input logic [15:0] vmax_act, // active max velocity
    input logic [15:0] ref_vel_in, // reference in
    input logic [15:0] ref_vel_out, // reference out
    input logic [15:0] pp_vel_out, // capped pp velocity
    input logic [31:0] par_wdata, // write value
    input logic [31:0] scale_num, // numerator
    input logic [31:0] acc_act, // active acceleration
    input logic [31:0] target_pos // target position
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence wr_to(a);
        par_wr && par_addr == a;
    endsequence
    sequence abs_ok;
        wr_to(`MPP_A_ABS) ##1 (par_ack && !par_err);
    endsequence
    ack_follows_a:
        assert property ((par_wr || par_rd) |=> par_ack) else $error("access without ack");
    err_with_ack_a:
        assert property (par_err |-> par_ack) else $error("refusal without ack");
    num_locked_a:
        assert property (wr_to(`MPP_A_NUM) ##0 stage_on |=> par_err && $stable(scale_num))
            else $error("numerator taken with stage on");
    jerk_locked_a:
        assert property (wr_to(`MPP_A_JERK) ##0 !op_end |=> par_err) else $error("jerk taken in motion");
    ramp_held_a:
        assert property (!motion_start |=> $stable(acc_act) && $stable(jerk_act))
            else $error("ramp changed without motion start");
    shape_held_a:
        assert property (!$rose(stage_on) |=> $stable(shape_act) && $stable(ss_vel_act))
            else $error("shape changed without stage enable");
    ref_clamp_a:
        assert property (vel_clamp_mode && ref_vel_in > vmax_act |=> ref_vel_out == $past(vmax_act))
            else $error("reference not clamped");
    pp_cap_a:
        assert property (pp_vel_out <= $past(vmax_act)) else $error("pp velocity above cap");
    abs_target_a:
        assert property (abs_ok |-> target_new && target_pos == $past(par_wdata))
            else $error("absolute target not applied");
    zero_standstill_a:
        assert property (pos_zero |-> $past(op_end) && target_pos == $past(par_wdata))
            else $error("position zeroed in motion");
endmodule // mpp_params_chk
bind mpp_params mpp_params_chk mpp_params_chk_i (.clock(clock), .rst_b(rst_b), .par_wr(par_wr), .par_rd(par_rd),
    .par_ack(par_ack), .par_err(par_err), .stage_on(stage_on), .op_end(op_end), .motion_start(motion_start),
    .vel_clamp_mode(vel_clamp_mode), .target_new(target_new), .pos_zero(pos_zero), .par_addr(par_addr),
    .jerk_act(jerk_act), .shape_act(shape_act), .ss_vel_act(ss_vel_act), .vmax_act(vmax_act),
    .ref_vel_in(ref_vel_in), .ref_vel_out(ref_vel_out), .pp_vel_out(pp_vel_out), .par_wdata(par_wdata),
    .scale_num(scale_num), .acc_act(acc_act), .target_pos(target_pos));

// ==== tb/tb_top.sv ====
// bench for the motion profile parameter set
// assumes the master model and the bound checker beside it
`timescale 1ns/10ps
`include "mpp_defines.vh"
module tb_top;
    typedef struct {logic [15:0] a; logic [31:0] d; logic e; logic [15:0] ra; logic [31:0] rx;} mpp_row_t;
    logic clock, rst_b, par_wr, par_rd, par_ack, par_err, stage_on, op_end, motion_start, sw_lim_en, e;
    logic vel_clamp_mode, target_new, pos_zero;
    logic [15:0] par_addr, ref_vel_in, jerk_act, vmax_act, shape_act, ss_vel_act, pp_vel_out, ref_vel_out;
    logic [31:0] par_wdata, par_rdata, motor_pos, sw_lim_min, sw_lim_max, scale_num, usr_lim_min, usr_lim_max;
    logic [31:0] acc_act, dec_act, pv_vel_out, target_pos, rd;
    int err_total = 0;
    int samples_checked = 0;
    mpp_row_t rows [19] = '{
        '{`MPP_A_NUM, 32'h0, 1'b1, `MPP_A_NUM, 32'h1},
        '{`MPP_A_NUM, 32'h5, 1'b0, `MPP_A_NUM, 32'h5},
        '{`MPP_A_VMAX, 32'h3b, 1'b1, `MPP_A_VMAX, 32'h3390},
        '{`MPP_A_VMAX, 32'h3c, 1'b0, `MPP_A_VMAX, 32'h3c},
        '{`MPP_A_ACC, 32'h0, 1'b1, `MPP_A_ACC, 32'h258},
        '{`MPP_A_DEC, 32'hc7, 1'b1, `MPP_A_DEC, 32'h2ee},
        '{`MPP_A_JERK, 32'h3, 1'b1, `MPP_A_JERK, 32'h0},
        '{`MPP_A_JERK, 32'h80, 1'b0, `MPP_A_JERK, 32'h80},
        '{`MPP_A_TYPE, 32'h1, 1'b1, `MPP_A_TYPE, 32'h0},
        '{`MPP_A_TYPE, 32'hffff, 1'b0, `MPP_A_TYPE, 32'hffff},
        '{`MPP_A_PPV, 32'hbb9, 1'b1, `MPP_A_PPV, 32'h3c},
        '{`MPP_A_PPV, 32'hbb8, 1'b0, `MPP_A_PPV, 32'hbb8},
        '{`MPP_A_PV, 32'hbb9, 1'b1, `MPP_A_PV, 32'h0},
        '{`MPP_A_PV, 32'hfffff448, 1'b0, `MPP_A_PV, 32'hfffff448},
        '{`MPP_A_COMB, 32'h000a0014, 1'b0, `MPP_A_ACC, 32'h64},
        '{`MPP_A_COMB, 32'h00010013, 1'b1, `MPP_A_DEC, 32'hc8},
        '{`MPP_A_ACC, 32'h2dc6c1, 1'b1, `MPP_A_ACC, 32'h64},
        '{`MPP_A_ACC, 32'h2dc6c0, 1'b0, `MPP_A_COMB, 32'hffff0014},
        '{16'h0800, 32'h0, 1'b1, `MPP_A_PPV, 32'hbb8}};
    mpp_params mpp_params_i (.clock(clock), .rst_b(rst_b), .par_addr(par_addr), .par_wdata(par_wdata),
        .par_wr(par_wr), .par_rd(par_rd), .par_rdata(par_rdata), .par_ack(par_ack), .par_err(par_err),
        .stage_on(stage_on), .op_end(op_end), .motion_start(motion_start), .motor_pos(motor_pos),
        .sw_lim_en(sw_lim_en), .sw_lim_min(sw_lim_min), .sw_lim_max(sw_lim_max),
        .vel_clamp_mode(vel_clamp_mode), .ref_vel_in(ref_vel_in), .scale_num(scale_num),
        .usr_lim_min(usr_lim_min), .usr_lim_max(usr_lim_max), .acc_act(acc_act), .dec_act(dec_act),
        .jerk_act(jerk_act), .vmax_act(vmax_act), .shape_act(shape_act), .ss_vel_act(ss_vel_act),
        .pp_vel_out(pp_vel_out), .pv_vel_out(pv_vel_out), .ref_vel_out(ref_vel_out),
        .target_pos(target_pos), .target_new(target_new), .pos_zero(pos_zero));
    mpp_master mpp_master_i (.clock(clock), .par_ack(par_ack), .par_err(par_err), .par_rdata(par_rdata),
        .par_addr(par_addr), .par_wdata(par_wdata), .par_wr(par_wr), .par_rd(par_rd));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        mpp_master_i.access(1'b1, a, d, e, rd);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #50us;
        err_total++;
        give_verdict();
    end
    initial begin
        {rst_b, stage_on, motion_start, sw_lim_en, vel_clamp_mode} = '0;
        {op_end, motor_pos, sw_lim_min, sw_lim_max, ref_vel_in} = {1'b1, 32'h0, 32'h80000000, 32'h7fffffff, 16'h0};
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        #1;
        chk("acc_act", acc_act, 32'h258);
        chk("dec_act", dec_act, 32'h2ee);
        chk("vmax_act", {16'h0, vmax_act}, 32'h3390);
        chk("scale_num", scale_num, 32'h1);
        chk("usr_lim_min", usr_lim_min, 32'h80000000);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk("refusal", {31'h0, e}, {31'h0, rows[i].e});
            mpp_master_i.access(1'b0, rows[i].ra, 32'h0, e, rd);
            chk("readback", rd, rows[i].rx);
        end
        $display("table test done");
        chk("acc_held", acc_act, 32'h258);
        @(posedge clock) motion_start <= 1'b1;
        @(posedge clock) motion_start <= 1'b0;
        #1;
        chk("acc_act", acc_act, `MPP_RAMP_MAX);
        chk("dec_act", dec_act, 32'hc8);
        chk("jerk_act", {16'h0, jerk_act}, 32'h80);
        @(posedge clock) {vel_clamp_mode, ref_vel_in} <= {1'b1, 16'd100};
        repeat (2) @(posedge clock);
        #1;
        chk("ref_vel_out", {16'h0, ref_vel_out}, 32'h3c);
        chk("pp_vel_out", {16'h0, pp_vel_out}, 32'h3c);
        chk("pv_vel_out", pv_vel_out, 32'hffffffc4);
        @(posedge clock) vel_clamp_mode <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk("ref_free", {16'h0, ref_vel_out}, 32'h64);
        $display("apply test done");
        wr(`MPP_A_SS, 32'h64);
        chk("ss_held", {16'h0, ss_vel_act}, 32'h0);
        @(posedge clock) stage_on <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk("ss_vel_act", {16'h0, ss_vel_act}, 32'h64);
        chk("shape_act", {16'h0, shape_act}, 32'hffff);
        wr(`MPP_A_NUM, 32'h7);
        chk("num_refused", {31'h0, e}, 32'h1);
        chk("scale_num", scale_num, 32'h5);
        wr(`MPP_A_VMAX, 32'h64);
        chk("vmax_refused", {31'h0, e}, 32'h1);
        $display("stage test done");
        chk("usr_lim_max", usr_lim_max, 32'h0fffffff);
        @(posedge clock) {op_end, motor_pos} <= {1'b0, 32'd200};
        wr(`MPP_A_ABS, 32'd1000);
        chk("target_abs", target_pos, 32'd1000);
        chk("target_new", {31'h0, target_new}, 32'h1);
        wr(`MPP_A_RELA, 32'd50);
        chk("target_rela", target_pos, 32'd250);
        wr(`MPP_A_RELT, 32'd30);
        chk("target_relt", target_pos, 32'd280);
        wr(`MPP_A_ABS, 32'h10000000);
        chk("abs_refused", {31'h0, e}, 32'h1);
        wr(`MPP_A_RELA, 32'h0ffffff0);
        chk("overrun_moving", {31'h0, e}, 32'h1);
        wr(`MPP_A_JERK, 32'h4);
        chk("jerk_refused", {31'h0, e}, 32'h1);
        @(posedge clock) op_end <= 1'b1;
        wr(`MPP_A_RELA, 32'h0ffffff0);
        chk("overrun_still", target_pos, 32'h0ffffff0);
        chk("pos_zero", {31'h0, pos_zero}, 32'h1);
        @(posedge clock) {sw_lim_en, sw_lim_max} <= {1'b1, 32'd500};
        wr(`MPP_A_ABS, 32'd600);
        chk("soft_refused", {31'h0, e}, 32'h1);
        chk("soft_lim_max", usr_lim_max, 32'd500);
        chk("lim_min", usr_lim_min, 32'hf0000000);
        $display("target test done");
        @(posedge clock) {rst_b, stage_on} <= 2'b00;
        repeat (2) @(posedge clock);
        #1;
        chk("rst_scale", scale_num, `MPP_RST_NUM);
        chk("rst_acc", acc_act, `MPP_RST_ACC);
        chk("rst_target", target_pos, 32'h0);
        @(posedge clock) rst_b <= 1'b1;
        mpp_master_i.access(1'b0, `MPP_A_PPV, 32'h0, e, rd);
        chk("rst_ppv", rd, 32'h3c);
        $display("midrun reset test done");
        give_verdict();
    end
endmodule // tb_top
